/* File: rtl/sp4_serial_port.sv */
// Local design decision: the strobed register port.
`timescale 1ns/1ns
module sp4_serial_port (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [sp4_pkg::SP4_AW-1:0] bus_addr,
    input wire logic [sp4_pkg::SP4_DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [sp4_pkg::SP4_DW-1:0] bus_rdata,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd,
    output logic serial_irq
);
    import sp4_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] baud;
        logic [7:0] rx_buf;
        logic tx_pend;
        logic rx_pend;
        logic tx_busy;
        logic [10:0] tx_sh;
        logic [3:0] tx_cnt;
        logic [3:0] tx_sub;
        sp4_rx_state_t rx_st;
        logic [3:0] rx_sub;
        logic [3:0] rx_cnt;
        logic [8:0] rx_sh;
        logic s1;
        logic s2;
        logic txd;
        logic rxo;
        logic rxoe;
        logic irq;
        logic [7:0] rdata;
    } sp4_state_t;

    sp4_state_t q_reg;
    sp4_state_t q_next;

    logic tick;
    sp4_mode_t mode;
    logic sync_mode;
    logic nine_bit;
    logic wr_ctrl;
    logic wr_data;
    logic wr_baud;
    logic wr_pend;

    function automatic logic is_nine(input sp4_mode_t m);
        is_nine = (m == SP4_MODE_ASYNC9F) || (m == SP4_MODE_ASYNC9V);
    endfunction

    function automatic logic [3:0] frame_len(input sp4_mode_t m);
        frame_len = is_nine(m) ? SP4_FRAME9 : SP4_FRAME8;
    endfunction

    function automatic logic [3:0] data_len(input sp4_mode_t m);
        data_len = is_nine(m) ? SP4_DATA9 : SP4_DATA8;
    endfunction

    assign mode = sp4_mode_t'(q_reg.ctrl[SP4_CTRL_MODE_HI:SP4_CTRL_MODE_LO]);
    assign sync_mode = (mode == SP4_MODE_SYNC);
    assign nine_bit = is_nine(mode);

    assign wr_ctrl = bus_wr && (bus_addr == SP4_CTRL_ADDR);
    assign wr_data = bus_wr && (bus_addr == SP4_DATA_ADDR);
    assign wr_baud = bus_wr && (bus_addr == SP4_BAUD_ADDR);
    assign wr_pend = bus_wr && (bus_addr == SP4_PEND_ADDR);

    // fixed-rate mode ticks every clock, the rest follow the divisor
    sp4_baud #(
        .DIV_W(8)
    ) u_baud (
        .clk(clk),
        .resetn(resetn),
        .fixed_rate(mode == SP4_MODE_ASYNC9F),
        .divisor(q_reg.baud),
        .tick(tick)
    );

    always_comb begin
        logic tx_set;
        logic rx_set;
        logic rx_keep;
        logic clk_low;
        logic [3:0] rx_point;
        tx_set = 1'b0;
        rx_set = 1'b0;
        rx_keep = 1'b0;
        clk_low = 1'b0;
        rx_point = sync_mode ? SP4_SYNC_SAMPLE : SP4_SUB_LAST;
        q_next = q_reg;

        // rx pin into the clock domain
        q_next.s1 = rxd_in;
        q_next.s2 = q_reg.s1;

        if (wr_ctrl) begin
            q_next.ctrl = bus_wdata;
        end
        if (wr_baud) begin
            q_next.baud = bus_wdata;
        end

        // transmitter; a new write restarts any frame in flight
        if (wr_data) begin
            q_next.tx_busy = 1'b1;
            q_next.tx_cnt = 4'h0;
            q_next.tx_sub = 4'h0;
            if (sync_mode) begin
                q_next.tx_sh = {3'b111, bus_wdata};
            end else begin
                q_next.tx_sh = {1'b1, nine_bit ? q_reg.ctrl[SP4_CTRL_TB8] : 1'b1,
                                bus_wdata, 1'b0};
            end
        end else if (q_reg.tx_busy && tick) begin
            q_next.tx_sub = q_reg.tx_sub + 4'h1;
            if (q_reg.tx_sub == SP4_SUB_LAST) begin
                q_next.tx_sh = {1'b1, q_reg.tx_sh[10:1]};
                q_next.tx_cnt = q_reg.tx_cnt + 4'h1;
                if (sync_mode) begin
                    if (q_reg.tx_cnt == SP4_SYNC_BITS - 4'h1) begin
                        tx_set = 1'b1;
                        q_next.tx_busy = 1'b0;
                    end
                end else begin
                    // stop bit begins as the shift before it ends
                    if (q_reg.tx_cnt == frame_len(mode) - 4'h2) begin
                        tx_set = 1'b1;
                    end
                    if (q_reg.tx_cnt == frame_len(mode) - 4'h1) begin
                        q_next.tx_busy = 1'b0;
                    end
                end
            end
        end

        // receiver
        case (q_reg.rx_st)
            SP4_RX_IDLE: begin
                q_next.rx_sub = 4'h0;
                q_next.rx_cnt = 4'h0;
                if (q_reg.ctrl[SP4_CTRL_RE]) begin
                    if (sync_mode) begin
                        // shares the clock pin with tx, so wait for it
                        if (!q_reg.rx_pend && !q_reg.tx_busy) begin
                            q_next.rx_st = SP4_RX_DATA;
                        end
                    end else if (!q_reg.s2) begin
                        q_next.rx_st = SP4_RX_START;
                    end
                end
            end
            SP4_RX_START: begin
                if (tick) begin
                    q_next.rx_sub = q_reg.rx_sub + 4'h1;
                    if (q_reg.rx_sub == SP4_START_MID) begin
                        q_next.rx_sub = 4'h0;
                        // a glitch shorter than half a bit is dropped
                        if (q_reg.s2) begin
                            q_next.rx_st = SP4_RX_IDLE;
                        end else begin
                            q_next.rx_st = SP4_RX_DATA;
                        end
                    end
                end
            end
            SP4_RX_DATA: begin
                if (tick) begin
                    q_next.rx_sub = q_reg.rx_sub + 4'h1;
                    if (q_reg.rx_sub == rx_point && q_reg.rx_cnt != SP4_SYNC_BITS
                        || q_reg.rx_sub == rx_point && !sync_mode) begin
                        q_next.rx_sh = {q_reg.s2, q_reg.rx_sh[8:1]};
                        q_next.rx_cnt = q_reg.rx_cnt + 4'h1;
                        if (sync_mode) begin
                            if (q_reg.rx_cnt == SP4_SYNC_BITS - 4'h1) begin
                                rx_set = 1'b1;
                                q_next.rx_buf = {q_reg.s2, q_reg.rx_sh[8:2]};
                            end
                        end else if (q_reg.rx_cnt == data_len(mode) - 4'h1) begin
                            q_next.rx_st = SP4_RX_STOP;
                        end
                    end
                    // sync: finish the last clock period before idling
                    if (sync_mode && q_reg.rx_cnt == SP4_SYNC_BITS
                        && q_reg.rx_sub == SP4_SUB_LAST) begin
                        q_next.rx_st = SP4_RX_IDLE;
                    end
                end
            end
            SP4_RX_STOP: begin
                if (tick) begin
                    q_next.rx_sub = q_reg.rx_sub + 4'h1;
                    if (q_reg.rx_sub == SP4_SUB_LAST) begin
                        q_next.rx_st = SP4_RX_IDLE;
                        // multiprocessor: only address frames complete
                        rx_keep = !(nine_bit && q_reg.ctrl[SP4_CTRL_MP]
                                    && !q_reg.rx_sh[8]);
                        if (rx_keep) begin
                            rx_set = 1'b1;
                            // an unread byte is simply overwritten
                            if (nine_bit) begin
                                q_next.rx_buf = q_reg.rx_sh[7:0];
                                q_next.ctrl[SP4_CTRL_RB8] = q_reg.rx_sh[8];
                            end else begin
                                q_next.rx_buf = q_reg.rx_sh[8:1];
                                q_next.ctrl[SP4_CTRL_RB8] = q_reg.s2;
                            end
                        end
                    end
                end
            end
            default: begin
                q_next.rx_st = SP4_RX_IDLE;
            end
        endcase

        // pending: software clears by writing zero, hardware set wins
        q_next.tx_pend = (wr_pend ? bus_wdata[SP4_PEND_TX] : q_reg.tx_pend)
                         | tx_set;
        q_next.rx_pend = (wr_pend ? bus_wdata[SP4_PEND_RX] : q_reg.rx_pend)
                         | rx_set;

        q_next.irq = (q_next.tx_pend && q_next.ctrl[SP4_CTRL_TXIE])
                     || (q_next.rx_pend && q_next.ctrl[SP4_CTRL_RXIE]);

        // pin drivers, computed from the next state so they stay aligned
        if (sync_mode) begin
            clk_low = (q_next.tx_busy && !q_next.tx_sub[3])
                      || (q_next.rx_st == SP4_RX_DATA && !q_next.rx_sub[3]);
            q_next.txd = !clk_low;
            q_next.rxo = q_next.tx_sh[0];
            q_next.rxoe = q_next.tx_busy;
        end else begin
            q_next.txd = q_next.tx_busy ? q_next.tx_sh[0] : 1'b1;
            q_next.rxo = 1'b1;
            q_next.rxoe = 1'b0;
        end

        // read data valid only in the cycle after the strobe
        q_next.rdata = 8'h00;
        if (bus_rd) begin
            case (bus_addr)
                SP4_CTRL_ADDR: q_next.rdata = q_reg.ctrl;
                SP4_DATA_ADDR: q_next.rdata = q_reg.rx_buf;
                SP4_BAUD_ADDR: q_next.rdata = q_reg.baud;
                SP4_PEND_ADDR: begin
                    q_next.rdata[SP4_PEND_TX] = q_reg.tx_pend;
                    q_next.rdata[SP4_PEND_RX] = q_reg.rx_pend;
                end
                default: q_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_reg <= '0;
            q_reg.ctrl <= SP4_CTRL_RST;
            q_reg.baud <= SP4_BAUD_RST;
            q_reg.rx_buf <= SP4_RBUF_RST;
            q_reg.rx_st <= SP4_RX_IDLE;
            q_reg.tx_sh <= 11'h7FF;
            q_reg.s1 <= 1'b1;
            q_reg.s2 <= 1'b1;
            q_reg.txd <= 1'b1;
            q_reg.rxo <= 1'b1;
        end else begin
            q_reg <= q_next;
        end
    end

    // mode list: sync shift, async 8 variable, async 9 fixed, async 9 variable
    assign bus_rdata = q_reg.rdata;
    assign txd = q_reg.txd;
    assign rxd_out = q_reg.rxo;
    assign rxd_oe = q_reg.rxoe;
    assign serial_irq = q_reg.irq;

endmodule

/* File: pkg/sp4_pkg.sv */
package sp4_pkg;

    // register bus geometry
    localparam int SP4_AW = 8;
    localparam int SP4_DW = 8;

    // register byte addresses
    localparam logic [7:0] SP4_CTRL_ADDR = 8'hF6;
    localparam logic [7:0] SP4_DATA_ADDR = 8'hF7;
    localparam logic [7:0] SP4_BAUD_ADDR = 8'hF8;
    localparam logic [7:0] SP4_PEND_ADDR = 8'hF9;

    // reset values
    localparam logic [7:0] SP4_CTRL_RST = 8'h00;
    localparam logic [7:0] SP4_BAUD_RST = 8'h00;
    localparam logic [7:0] SP4_RBUF_RST = 8'h00;

    // serial_control fields
    localparam int SP4_CTRL_MODE_HI = 7;
    localparam int SP4_CTRL_MODE_LO = 6;
    localparam int SP4_CTRL_MP = 5;
    localparam int SP4_CTRL_RE = 4;
    localparam int SP4_CTRL_TB8 = 3;
    localparam int SP4_CTRL_RB8 = 2;
    localparam int SP4_CTRL_TXIE = 1;
    localparam int SP4_CTRL_RXIE = 0;

    // interrupt_pending fields
    localparam int SP4_PEND_TX = 4;
    localparam int SP4_PEND_RX = 5;

    // oversampling: sixteen ticks per bit
    localparam logic [3:0] SP4_SUB_LAST = 4'hF;
    localparam logic [3:0] SP4_START_MID = 4'h7;
    localparam logic [3:0] SP4_SYNC_SAMPLE = 4'h8;

    // frame and data lengths in bits
    localparam logic [3:0] SP4_SYNC_BITS = 4'h8;
    localparam logic [3:0] SP4_FRAME8 = 4'hA;
    localparam logic [3:0] SP4_FRAME9 = 4'hB;
    localparam logic [3:0] SP4_DATA8 = 4'h8;
    localparam logic [3:0] SP4_DATA9 = 4'h9;

    typedef enum logic [1:0] {
        SP4_MODE_SYNC = 2'b00,
        SP4_MODE_ASYNC8 = 2'b01,
        SP4_MODE_ASYNC9F = 2'b10,
        SP4_MODE_ASYNC9V = 2'b11
    } sp4_mode_t;

    typedef enum logic [1:0] {
        SP4_RX_IDLE = 2'b00,
        SP4_RX_START = 2'b01,
        SP4_RX_DATA = 2'b11,
        SP4_RX_STOP = 2'b10
    } sp4_rx_state_t;

endpackage

/* File: rtl/sp4_baud.sv */
`timescale 1ns/1ns
module sp4_baud #(
    parameter int DIV_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic fixed_rate,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick
);
    import sp4_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } sp4_baud_state_t;

    sp4_baud_state_t q_reg;
    sp4_baud_state_t q_next;

    // one tick every divisor+1 cycles, or every cycle at fixed rate
    always_comb begin
        q_next = q_reg;
        q_next.tick = fixed_rate || (q_reg.cnt == '0);
        if (q_reg.cnt == '0) begin
            q_next.cnt = divisor;
        end else begin
            q_next.cnt = q_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign tick = q_reg.tick;

endmodule

/* File: testbench/sp4_serial_port_assertions.sv */
`timescale 1ns/1ns
module sp4_serial_port_assertions (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [sp4_pkg::SP4_AW-1:0] bus_addr,
    input wire logic [sp4_pkg::SP4_DW-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [sp4_pkg::SP4_DW-1:0] bus_rdata,
    input wire logic rxd_oe,
    input wire logic txd,
    input wire logic serial_irq
);
    import sp4_pkg::*;
    logic [7:0] ctl_reg;
    logic [7:0] baud_reg;
    // shadows of software-owned fields only; hardware-written bits are masked below
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_reg <= 8'h00;
            baud_reg <= 8'h00;
        end else if (bus_wr && bus_addr == SP4_CTRL_ADDR) begin
            ctl_reg <= bus_wdata;
        end else if (bus_wr && bus_addr == SP4_BAUD_ADDR) begin
            baud_reg <= bus_wdata;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_RDATA_IDLE: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_UNMAPPED_ZERO: assert property ($past(bus_rd) && ($past(bus_addr) < SP4_CTRL_ADDR
        || $past(bus_addr) > SP4_PEND_ADDR) |-> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_READBACK: assert property ($past(bus_rd) && $past(bus_addr) == SP4_CTRL_ADDR
        |-> (bus_rdata & 8'hFB) == ($past(ctl_reg) & 8'hFB))
        else $error("control readback wrong");
    AST_BAUD_READBACK: assert property ($past(bus_rd) && $past(bus_addr) == SP4_BAUD_ADDR
        |-> bus_rdata == $past(baud_reg))
        else $error("divisor readback wrong");
    AST_IRQ_GATED: assert property (ctl_reg[1:0] == 2'b00 && $past(ctl_reg[1:0]) == 2'b00
        |-> !serial_irq)
        else $error("interrupt with both enables off");
    AST_TX_START: assert property (bus_wr && bus_addr == SP4_DATA_ADDR && ctl_reg[6]
        |-> ##[1:4] !txd)
        else $error("no start bit after data write");
    AST_FIXED_START: assert property (bus_wr && bus_addr == SP4_DATA_ADDR
        && ctl_reg[7:6] == 2'b10 |=> (!txd) [*8])
        else $error("fixed rate start bit too short");
    AST_OE_SYNC_ONLY: assert property (rxd_oe |-> $past(ctl_reg[7:6]) == 2'b00)
        else $error("receive pin driven outside synchronous mode");
    AST_SYNC_CLOCK: assert property ($fell(txd) && ctl_reg[7:6] == 2'b00 && baud_reg == 8'h00
        |=> (!txd) [*7] ##1 txd)
        else $error("shift clock low phase not eight cycles");
endmodule
bind sp4_serial_port sp4_serial_port_assertions u_sp4_serial_port_assertions (
    .clk(clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rxd_oe(rxd_oe),
    .txd(txd), .serial_irq(serial_irq)
);

/* File: testbench/sp4_peer_model.sv */
`timescale 1ns/1ns
module sp4_peer_model (
    input wire logic clk,
    input wire logic txd,
    input wire logic rxd_pin,
    output logic rxd_drv
);
    initial rxd_drv = 1'b1;
    // eight-bit frames put the stop bit where the ninth bit would sit
    task automatic send(input logic [8:0] d, input int nb, input int bt);
        logic [10:0] f;
        f = {2'b11, d, 1'b0};
        if (nb == 8) f[9] = 1'b1;
        for (int i = 0; i < nb + 2; i++) begin
            rxd_drv <= f[i];
            repeat (bt) @(posedge clk);
        end
    endtask
    task automatic recv(input int nb, input int bt, output logic [9:0] d);
        d = '1;
        @(negedge txd);
        repeat (bt / 2) @(posedge clk);
        for (int i = 0; i <= nb; i++) begin
            repeat (bt) @(posedge clk);
            d[i] = txd;
        end
    endtask
    task automatic sync_get(output logic [9:0] d);
        d = '0;
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            d[i] = rxd_pin;
        end
    endtask
    task automatic sync_put(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd);
            rxd_drv <= d[i];
        end
        @(posedge txd);
        repeat (4) @(posedge clk);
        // no pull on this line: show the inverse rather than a stale level
        rxd_drv <= ~d[7];
    endtask
endmodule

/* File: testbench/sp4_serial_port_tb_top.sv */
`timescale 1ns/1ns
module sp4_serial_port_tb_top;
    import sp4_pkg::*;
    typedef struct packed {logic [7:0] ctl; logic [7:0] baud; logic [8:0] dat;} sp4_row_t;
    localparam sp4_row_t ROWS [4] = '{'{8'h5B, 8'h00, 9'h155}, '{8'h93, 8'h03, 9'h0A3},
        '{8'hDB, 8'h02, 9'h13C}, '{8'hD3, 8'h00, 9'h0FF}};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [7:0] bus_wdata = 8'h00;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_rdata;
    logic rxd_out, rxd_oe, txd, serial_irq, rxd_drv;
    wire logic rxd_pin = rxd_oe ? rxd_out : rxd_drv;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    int bt;
    int nb;
    logic [9:0] v;
    sp4_serial_port u_sp4_serial_port (.clk(clk), .resetn(resetn), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .rxd_in(rxd_pin), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd),
        .serial_irq(serial_irq));
    sp4_peer_model u_peer (.clk(clk), .txd(txd), .rxd_pin(rxd_pin), .rxd_drv(rxd_drv));
    always #2 clk = ~clk;
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // a spare cycle after each strobe keeps one assignment per signal per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [9:0] exp);
        logic [9:0] d;
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1 d = {2'b00, bus_rdata};
        @(posedge clk);
        chk(d, exp);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        foreach (ROWS[i]) begin
            bt = (ROWS[i].ctl[7:6] == 2'b10) ? 16 : 16 * (ROWS[i].baud + 1);
            nb = ROWS[i].ctl[7] ? 9 : 8;
            wr(SP4_BAUD_ADDR, ROWS[i].baud);
            wr(SP4_CTRL_ADDR, ROWS[i].ctl);
            fork
                u_peer.recv(nb, bt, v);
                wr(SP4_DATA_ADDR, ROWS[i].dat[7:0]);
            join
            chk(v, {1'b1, ROWS[i].dat});
            rdc(SP4_PEND_ADDR, 10'h010);
            chk({9'h000, serial_irq}, 10'h001);
            wr(SP4_PEND_ADDR, 8'h00);
            u_peer.send(ROWS[i].dat ^ 9'h0FF, nb, bt);
            rdc(SP4_PEND_ADDR, 10'h020);
            rdc(SP4_DATA_ADDR, {2'b00, ~ROWS[i].dat[7:0]});
            rdc(SP4_CTRL_ADDR, {2'b00, ROWS[i].ctl[7:3], ROWS[i].dat[8], ROWS[i].ctl[1:0]});
            wr(SP4_PEND_ADDR, 8'h00);
            $display("frame test %0d done", i);
        end
        u_peer.send(9'h011, 9, 16);
        u_peer.send(9'h022, 9, 16);
        rdc(SP4_DATA_ADDR, 10'h022);
        wr(SP4_PEND_ADDR, 8'h00);
        u_peer.send(9'h1FF, 8, 3);
        repeat (40) @(posedge clk);
        rdc(SP4_PEND_ADDR, 10'h000);
        wr(SP4_CTRL_ADDR, 8'h43);
        u_peer.send(9'h1A5, 8, 16);
        rdc(SP4_PEND_ADDR, 10'h000);
        wr(SP4_CTRL_ADDR, 8'hB3);
        u_peer.send(9'h0A5, 9, 16);
        rdc(SP4_PEND_ADDR, 10'h000);
        u_peer.send(9'h1A6, 9, 16);
        rdc(SP4_DATA_ADDR, 10'h0A6);
        wr(SP4_PEND_ADDR, 8'h20);
        repeat (2) @(posedge clk);
        chk({9'h000, serial_irq}, 10'h001);
        wr(SP4_CTRL_ADDR, 8'hB2);
        repeat (2) @(posedge clk);
        chk({9'h000, serial_irq}, 10'h000);
        wr(SP4_PEND_ADDR, 8'h00);
        wr(8'hF5, 8'hFF);
        rdc(8'hF5, 10'h000);
        rdc(8'hFA, 10'h000);
        $display("async corner tests done");
        wr(SP4_BAUD_ADDR, 8'h00);
        wr(SP4_CTRL_ADDR, 8'h02);
        fork
            u_peer.sync_get(v);
            wr(SP4_DATA_ADDR, 8'hC5);
        join
        chk(v, 10'h0C5);
        repeat (20) @(posedge clk);
        rdc(SP4_PEND_ADDR, 10'h010);
        wr(SP4_PEND_ADDR, 8'h00);
        fork
            u_peer.sync_put(8'h9A);
            wr(SP4_CTRL_ADDR, 8'h10);
        join
        rdc(SP4_PEND_ADDR, 10'h020);
        rdc(SP4_DATA_ADDR, 10'h09A);
        wr(SP4_CTRL_ADDR, 8'h00);
        $display("sync tests done");
        wr(SP4_CTRL_ADDR, 8'hEF);
        wr(SP4_BAUD_ADDR, 8'h07);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rdc(SP4_CTRL_ADDR, 10'h000);
        rdc(SP4_BAUD_ADDR, 10'h000);
        rdc(SP4_PEND_ADDR, 10'h000);
        chk({9'h000, txd}, 10'h001);
        $display("reset test done");
        close_out();
    end
endmodule
